/* File: verilog/ack_seq_pkg.sv */
// Shared constants and types for the input acknowledge sequencer.
package ack_seq_pkg;
	// Clock period and acknowledge widths in nanoseconds.
	localparam int CLK_NS = 8;
	localparam int ACK_FAST_NS = 2250;
	localparam int ACK_SLOW_NS = 14750;
	// Least times round up to whole cycles.
	localparam int ACK_FAST_CYC = (ACK_FAST_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACK_SLOW_CYC = (ACK_SLOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACK_CNT_W = 11;
	// Slot index is (time - 1) * 4 + (phase - 1).
	localparam logic [3:0] SLOT_T12 = 4'h1;
	localparam logic [3:0] SLOT_T13 = 4'h2;
	localparam logic [3:0] SLOT_T14 = 4'h3;
	localparam logic [3:0] SLOT_T21 = 4'h4;
	localparam logic [3:0] SLOT_T22 = 4'h5;
	localparam logic [3:0] SLOT_T24 = 4'h7;
	localparam logic [3:0] SLOT_T41 = 4'hC;
	localparam logic [3:0] SLOT_LAST = 4'hF;
	// Register byte addresses.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FUNC = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_INT_STAT = 8'h0C;
	localparam logic [7:0] ADDR_INT_MASK = 8'h10;
	localparam logic [7:0] ADDR_RD_ADDR = 8'h14;
	localparam logic [7:0] ADDR_RD_DATA = 8'h18;
	localparam logic [7:0] ADDR_MON = 8'h1C;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Interrupt event bit positions.
	localparam int EV_STORED = 0;
	localparam int EV_ACK_DONE = 1;
	localparam int EV_MONITOR = 2;
	localparam int EV_INACTIVE = 3;
	localparam int EV_W = 4;
	localparam int CH_SEL_W = 4;
	// Control register layout, bit 31 downward.
	typedef struct packed {
		logic [19:0] unused;
		logic [3:0] channel_sel;
		logic output_or_external_function;
		logic bootstrap_readonly_address;
		logic cont_data_req;
		logic terminate;
		logic monitor_req;
		logic slow_interface;
		logic paired_channel_flag;
		logic activate;
	} ctrl_s;
	localparam ctrl_s CTRL_RESET = '0;
	typedef enum logic [1:0] {ST_IDLE, ST_SEQ1, ST_SEQ2} seq_e;
endpackage : ack_seq_pkg

/* File: verilog/word_store.sv */
// Small memory that keeps the stored input words for software read-back.
`timescale 1ns/1ns
`default_nettype none
module word_store #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic ce_i,
	input wire logic we_i,
	input wire logic [$clog2(DEPTH)-1:0] waddr_i,
	input wire logic [WIDTH-1:0] wdata_i,
	input wire logic [$clog2(DEPTH)-1:0] raddr_i,
	output logic [WIDTH-1:0] rdata_o
);
	logic [WIDTH-1:0] mem [DEPTH];

	// Write port and registered read port.
	always_ff @(posedge clk_i)
	begin
		if (ce_i)
		begin
			if (we_i)
				mem[waddr_i] <= wdata_i;
			rdata_o <= mem[raddr_i];
		end
	end
endmodule : word_store
`default_nettype wire

/* File: verilog/input_channel_ack_sequencer.sv */
// Input sequence control, acknowledge generator and register slave.
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module input_channel_ack_sequencer #(
	parameter int WORD_W = 18,
	parameter int NUM_CH = 16,
	parameter int STORE_DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic input_data_request_i,
	input wire logic [WORD_W-1:0] input_data_i,
	output logic input_acknowledge_o,
	output logic store_select_o,
	output logic [WORD_W-1:0] memory_write_register_o,
	output logic mem_write_inhibit_o,
	output logic cm_addr_inhibit_o,
	output logic bnet_17_16_inhibit_o,
	output logic irq_o,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int SA_W = $clog2(STORE_DEPTH);

	// Refuse sizes that the register layout or the acknowledge counter cannot hold.
	if (WORD_W < 18 || WORD_W > 32 || NUM_CH < 1 || NUM_CH > 16 || STORE_DEPTH < 2
		|| ack_seq_pkg::ACK_SLOW_CYC >= (1 << ack_seq_pkg::ACK_CNT_W))
	begin : g_bad_size
		$error("input_channel_ack_sequencer: unsupported parameters");
	end

	ack_seq_pkg::ctrl_s ctrl_r;
	ack_seq_pkg::seq_e state_r;
	logic [NUM_CH-1:0] func_sel_r, monitor_r;
	logic [ack_seq_pkg::EV_W-1:0] int_stat_r, int_mask_r, ev;
	logic [3:0] slot_r;
	logic [3:0] chan_r;
	logic req_m_r, req_s_r, armed_r, active_r, second_r, pair_lat_r, slow_lat_r;
	logic [WORD_W-1:0] data_m_r, data_s_r, rd_word;
	logic [ack_seq_pkg::ACK_CNT_W-1:0] ack_cnt_r;
	logic ack_gen_r, we_r;
	logic [SA_W-1:0] wr_ptr_r, rd_addr_r;
	logic aw_got_r, w_got_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r, wr_mask;
	logic [3:0] w_strb_r;
	logic wr_do, start, in_seq, at_t14, at_t41_2, ack_set, mon_set, act_clr;

	// Two-stage synchronisers for the request and data pins.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			req_m_r <= 1'b0;
			req_s_r <= 1'b0;
			data_m_r <= '0;
			data_s_r <= '0;
		end
		else if (ce_i)
		begin
			req_m_r <= input_data_request_i;
			req_s_r <= req_m_r;
			data_m_r <= input_data_i;
			data_s_r <= data_m_r;
		end
	end

	// Decodes of the sequence slots.
	assign in_seq = state_r != ack_seq_pkg::ST_IDLE;
	assign start = state_r == ack_seq_pkg::ST_IDLE && req_s_r && armed_r && active_r && !ack_gen_r;
	assign at_t14 = in_seq && slot_r == ack_seq_pkg::SLOT_T14;
	assign at_t41_2 = state_r == ack_seq_pkg::ST_SEQ2 && slot_r == ack_seq_pkg::SLOT_T41;
	assign ack_set = (state_r == ack_seq_pkg::ST_SEQ1 && at_t14 && !pair_lat_r) || at_t41_2;
	assign mon_set = in_seq && slot_r == ack_seq_pkg::SLOT_T13 && !ctrl_r.terminate
		&& ctrl_r.monitor_req;
	assign act_clr = in_seq && slot_r == ack_seq_pkg::SLOT_T13 && !ctrl_r.terminate
		&& !ctrl_r.cont_data_req;
	assign wr_do = aw_got_r && w_got_r && !s_axi_bvalid;

	// Sequence state, slot counter and second-sequence request.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_r <= ack_seq_pkg::ST_IDLE;
			slot_r <= '0;
			second_r <= 1'b0;
			pair_lat_r <= 1'b0;
			slow_lat_r <= 1'b0;
			chan_r <= '0;
		end
		else if (ce_i)
		begin
			slot_r <= in_seq ? slot_r + 4'h1 : '0;
			if (start)
			begin
				state_r <= ack_seq_pkg::ST_SEQ1;
				chan_r <= ctrl_r.channel_sel;
				// Indexed mode is taken from the selected channel's selector only.
				pair_lat_r <= ctrl_r.paired_channel_flag | func_sel_r[ctrl_r.channel_sel];
				slow_lat_r <= ctrl_r.slow_interface;
			end
			if (state_r == ack_seq_pkg::ST_SEQ1 && slot_r == ack_seq_pkg::SLOT_T22 && pair_lat_r
				&& !ctrl_r.output_or_external_function)
				second_r <= 1'b1;
			if (slot_r == ack_seq_pkg::SLOT_LAST && in_seq)
			begin
				// The second pass re-runs the slot commands except the T14 acknowledge and the T22 request; its T41 sets the acknowledge and drops bnet_17_16_inhibit_o.
				state_r <= second_r ? ack_seq_pkg::ST_SEQ2 : ack_seq_pkg::ST_IDLE;
				second_r <= 1'b0;
			end
		end
	end

	// Store path steering, write register and inhibits.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			store_select_o <= 1'b0;
			memory_write_register_o <= '0;
			we_r <= 1'b0;
			wr_ptr_r <= '0;
			mem_write_inhibit_o <= 1'b0;
			cm_addr_inhibit_o <= 1'b0;
			bnet_17_16_inhibit_o <= 1'b0;
		end
		else if (ce_i)
		begin
			we_r <= 1'b0;
			if (we_r)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (in_seq && slot_r == ack_seq_pkg::SLOT_T12)
				store_select_o <= 1'b1;
			if (in_seq && slot_r == ack_seq_pkg::SLOT_T21)
				store_select_o <= 1'b0;
			if (at_t14 && !ctrl_r.bootstrap_readonly_address)
			begin
				memory_write_register_o <= data_s_r;
				we_r <= 1'b1;
			end
			if (start)
			begin
				mem_write_inhibit_o <= 1'b1;
				cm_addr_inhibit_o <= 1'b1;
				bnet_17_16_inhibit_o <= 1'b1;
			end
			if (in_seq && slot_r == ack_seq_pkg::SLOT_T24)
			begin
				mem_write_inhibit_o <= 1'b0;
				cm_addr_inhibit_o <= 1'b0;
			end
			if (at_t41_2)
				bnet_17_16_inhibit_o <= 1'b0;
		end
	end

	// Acknowledge generator; the pulse width is the generator's set time.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ack_gen_r <= 1'b0;
			ack_cnt_r <= '0;
		end
		else if (ce_i)
		begin
			if (ack_set)
			begin
				ack_gen_r <= 1'b1;
				ack_cnt_r <= slow_lat_r ? ack_seq_pkg::ACK_CNT_W'(ack_seq_pkg::ACK_SLOW_CYC)
					: ack_seq_pkg::ACK_CNT_W'(ack_seq_pkg::ACK_FAST_CYC);
			end
			else if (ack_gen_r)
			begin
				ack_cnt_r <= ack_cnt_r - 1'b1;
				if (ack_cnt_r == ack_seq_pkg::ACK_CNT_W'(1))
					ack_gen_r <= 1'b0;
			end
		end
	end
	assign input_acknowledge_o = ack_gen_r;

	// Re-arm only once the request has dropped after an acknowledge.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			armed_r <= 1'b1;
		else if (ce_i)
		begin
			if (start)
				armed_r <= 1'b0;
			else if (!req_s_r && !in_seq)
				armed_r <= 1'b1;
		end
	end

	// Channel active flag: software activation wins over the sequence clear.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			active_r <= 1'b0;
		else if (ce_i)
		begin
			if (wr_do && aw_addr_r == ack_seq_pkg::ADDR_CTRL && w_strb_r[0] && w_data_r[0])
				active_r <= 1'b1;
			else if (act_clr)
				active_r <= 1'b0;
		end
	end

	// Per-channel monitor flags, cleared by writing one; a set wins.
	assign wr_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
	generate
		for (genvar i = 0; i < NUM_CH; i++)
		begin : g_mon
			localparam logic [3:0] CH_IDX = 4'(i);
			always_ff @(posedge clk_i or posedge rst_i)
			begin
				if (rst_i)
					monitor_r[i] <= 1'b0;
				else if (ce_i)
				begin
					if (mon_set && chan_r == CH_IDX)
						monitor_r[i] <= 1'b1;
					else if (wr_do && aw_addr_r == ack_seq_pkg::ADDR_MON && (w_data_r[i] & wr_mask[i]))
						monitor_r[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// Interrupt status, mask and the level interrupt.
	assign ev = {act_clr & active_r, mon_set, ack_gen_r & (ack_cnt_r == ack_seq_pkg::ACK_CNT_W'(1)), we_r};
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			int_stat_r <= '0;
			irq_o <= 1'b0;
		end
		else if (ce_i)
		begin
			if (wr_do && aw_addr_r == ack_seq_pkg::ADDR_INT_STAT)
				int_stat_r <= (int_stat_r & ~(w_data_r[ack_seq_pkg::EV_W-1:0]
					& wr_mask[ack_seq_pkg::EV_W-1:0])) | ev;
			else
				int_stat_r <= int_stat_r | ev;
			irq_o <= |((int_stat_r | ev) & int_mask_r);
		end
	end

	// Software-written registers.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ctrl_r <= ack_seq_pkg::CTRL_RESET;
			func_sel_r <= '0;
			int_mask_r <= '0;
			rd_addr_r <= '0;
		end
		else if (ce_i && wr_do)
		begin
			unique case (aw_addr_r)
				ack_seq_pkg::ADDR_CTRL: ctrl_r <= (ctrl_r & ~wr_mask) | (w_data_r & wr_mask & 32'hFFE);
				ack_seq_pkg::ADDR_FUNC: func_sel_r <= (func_sel_r & ~wr_mask[NUM_CH-1:0])
					| (w_data_r[NUM_CH-1:0] & wr_mask[NUM_CH-1:0]);
				ack_seq_pkg::ADDR_INT_MASK: int_mask_r <= w_data_r[ack_seq_pkg::EV_W-1:0];
				ack_seq_pkg::ADDR_RD_ADDR: rd_addr_r <= w_data_r[SA_W-1:0];
				default: ;
			endcase
		end
	end

	// AXI4-Lite write channels, taken in either order.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ack_seq_pkg::RESP_OKAY;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end
		else if (ce_i)
		begin
			s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_got_r;
			s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_got_r;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_do)
			begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_r[1:0] != 2'h0 || aw_addr_r > ack_seq_pkg::ADDR_MON)
					? ack_seq_pkg::RESP_SLVERR : ack_seq_pkg::RESP_OKAY;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// AXI4-Lite read channel.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= ack_seq_pkg::RESP_OKAY;
		end
		else if (ce_i)
		begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= ack_seq_pkg::RESP_OKAY;
				unique case (s_axi_araddr)
					ack_seq_pkg::ADDR_CTRL: s_axi_rdata <= ctrl_r | 32'(active_r);
					ack_seq_pkg::ADDR_FUNC: s_axi_rdata <= 32'(func_sel_r);
					ack_seq_pkg::ADDR_STAT: s_axi_rdata <= {16'h0000, 10'h000, armed_r, store_select_o,
						state_r, ack_gen_r, active_r};
					ack_seq_pkg::ADDR_INT_STAT: s_axi_rdata <= 32'(int_stat_r);
					ack_seq_pkg::ADDR_INT_MASK: s_axi_rdata <= 32'(int_mask_r);
					ack_seq_pkg::ADDR_RD_ADDR: s_axi_rdata <= 32'(rd_addr_r);
					ack_seq_pkg::ADDR_RD_DATA: s_axi_rdata <= 32'(rd_word);
					ack_seq_pkg::ADDR_MON: s_axi_rdata <= 32'(monitor_r);
					default:
					begin
						s_axi_rdata <= '0;
						s_axi_rresp <= ack_seq_pkg::RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Stored words kept for read-back.
	word_store #(.WIDTH(WORD_W), .DEPTH(STORE_DEPTH)) u_store (
		.clk_i(clk_i),
		.ce_i(ce_i),
		.we_i(we_r),
		.waddr_i(wr_ptr_r),
		.wdata_i(memory_write_register_o),
		.raddr_i(rd_addr_r),
		.rdata_o(rd_word)
	);

	// Cycle count of the acknowledge, read only by the checks below.
	logic [ack_seq_pkg::ACK_CNT_W-1:0] ack_len_r;
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			ack_len_r <= '0;
		else if (ce_i)
			ack_len_r <= ack_gen_r ? ack_len_r + 1'b1 : '0;
	end
	localparam int FAST_LEN = ack_seq_pkg::ACK_FAST_CYC;
	localparam int SLOW_LEN = ack_seq_pkg::ACK_SLOW_CYC;

	// Word stored in the current sequence, read only by the checks below.
	logic stored_r;
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			stored_r <= 1'b0;
		else if (ce_i)
		begin
			if (we_r)
				stored_r <= 1'b1;
			else if (start || (slot_r == ack_seq_pkg::SLOT_LAST && in_seq))
				stored_r <= 1'b0;
		end
	end

	// Checks of the slot commands and acknowledge timing.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_width: assert property ($fell(ack_gen_r) |-> ack_len_r == (slow_lat_r ? SLOW_LEN : FAST_LEN))
		else $error("acknowledge width wrong");
	a_ack_after_store: assert property ($rose(ack_gen_r) && !ctrl_r.bootstrap_readonly_address
		|-> stored_r || we_r)
		else $error("acknowledge without a stored word");
	a_pair_withhold: assert property ($rose(ack_gen_r) && pair_lat_r
		|-> $past(state_r) == ack_seq_pkg::ST_SEQ2)
		else $error("paired acknowledge before second word");
	a_single_ack_t14: assert property (ce_i && state_r == ack_seq_pkg::ST_SEQ1 && at_t14 && !pair_lat_r
		|=> ack_gen_r ##1 ack_gen_r)
		else $error("unpaired acknowledge not set");
	a_second_seq_set: assert property (ce_i && state_r == ack_seq_pkg::ST_SEQ1 && pair_lat_r
		&& slot_r == ack_seq_pkg::SLOT_T22 && !ctrl_r.output_or_external_function
		|=> second_r)
		else $error("second sequence not requested");
	a_seq2_ack_t41: assert property (ce_i && at_t41_2 |=> ack_gen_r && !bnet_17_16_inhibit_o)
		else $error("second sequence acknowledge or release missing");
	a_steer_drop: assert property (ce_i && in_seq && slot_r == ack_seq_pkg::SLOT_T21
		|=> !store_select_o)
		else $error("store steering not dropped");
	a_store_word: assert property (ce_i && at_t14 && !ctrl_r.bootstrap_readonly_address
		|=> we_r && memory_write_register_o == $past(data_s_r))
		else $error("word not stored at first quarter");
	a_inhibit_release: assert property (ce_i && in_seq && slot_r == ack_seq_pkg::SLOT_T24
		|=> !mem_write_inhibit_o && !cm_addr_inhibit_o)
		else $error("inhibits not released");
	a_monitor_set: assert property (ce_i && mon_set |=> monitor_r[chan_r])
		else $error("monitor flag not set");
	c_single_ack: cover property ($rose(ack_gen_r) && !pair_lat_r);
	c_paired_ack: cover property ($rose(ack_gen_r) && pair_lat_r);
	c_slow_end: cover property ($fell(ack_gen_r) && slow_lat_r);
	c_irq: cover property ($rose(irq_o));
endmodule : input_channel_ack_sequencer
`default_nettype wire

/* File: test/equip_model.sv */
// Behavioural model of the equipment that sends input words to the block.
`timescale 1ns/1ns
`default_nettype none
module equip_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic go_i,
	input wire logic ack_i,
	input wire logic [17:0] word_i,
	input wire logic [7:0] hold_i,
	output logic req_o,
	output logic [17:0] data_o
);
	logic [7:0] wait_r;
	// Raise the request with a word, then drop it a chosen time after the acknowledge.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			req_o <= 1'b0;
			data_o <= 18'h0;
			wait_r <= 8'h0;
		end
		else if (!req_o && go_i)
		begin
			req_o <= 1'b1;
			data_o <= word_i;
		end
		else if (req_o && (ack_i || wait_r != 8'h0))
		begin
			if (wait_r == hold_i)
			begin
				req_o <= 1'b0;
				data_o <= ~data_o; // Released data no longer shows the word.
				wait_r <= 8'h0;
			end
			else
				wait_r <= wait_r + 8'h1;
		end
	end
endmodule : equip_model
`default_nettype wire

/* File: test/input_channel_ack_sequencer_test.sv */
// Self-checking testbench for the input acknowledge sequencer.
`timescale 1ns/1ns
`default_nettype none
module input_channel_ack_sequencer_test;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic go = 1'b0;
	logic ce = 1'b1;
	logic [17:0] word = 18'h0;
	logic [7:0] hold_n = 8'h0;
	logic req, ack, st_sel, wr_inh, cm_inh, bn_inh, irq, bn_at;
	logic [17:0] data, mwr, stored;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	int miscompares = 0, checks_done = 0, cyc = 0, lat, wid;
	// Free-running clock at 125 MHz.
	initial
	begin
		forever #4 clk_i = ~clk_i;
	end
	equip_model partner (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .ack_i(ack), .word_i(word),
		.hold_i(hold_n), .req_o(req), .data_o(data));
	input_channel_ack_sequencer uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.input_data_request_i(req), .input_data_i(data), .input_acknowledge_o(ack),
		.store_select_o(st_sel), .memory_write_register_o(mwr), .mem_write_inhibit_o(wr_inh),
		.cm_addr_inhibit_o(cm_inh), .bnet_17_16_inhibit_o(bn_inh), .irq_o(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	task automatic final_report;
		begin
			if (miscompares == 0 && checks_done > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask : final_report
	// Cuts a hung run short.
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			checks_done++;
			if (got !== exp)
			begin
				miscompares++;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask : chk
	// Register write: each channel released at its own handshake edge.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_t, w_t, b_t;
		begin
			awaddr <= a;
			wdata <= d;
			wstrb <= 4'hF;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			forever
			begin
				@(negedge clk_i);
				aw_t = awready & awvalid;
				w_t = wready & wvalid;
				b_t = bvalid;
				resp = bresp;
				@(posedge clk_i);
				if (aw_t)
					awvalid <= 1'b0;
				if (w_t)
					wvalid <= 1'b0;
				if (b_t)
					break;
			end
			bready <= 1'b0;
			@(posedge clk_i);
		end
	endtask : axi_wr
	// Register read: data and response taken at the edge where rvalid is high.
	task automatic axi_rd(input logic [7:0] a);
		logic ar_t, r_t;
		begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			forever
			begin
				@(negedge clk_i);
				ar_t = arready & arvalid;
				r_t = rvalid;
				rd = rdata;
				resp = rresp;
				@(posedge clk_i);
				if (ar_t)
					arvalid <= 1'b0;
				if (r_t)
					break;
			end
			rready <= 1'b0;
			@(posedge clk_i);
		end
	endtask : axi_rd
	// One word from the equipment; measures delay to acknowledge and its width.
	task automatic send_word(input logic [17:0] w, input logic [7:0] h);
		begin
			lat = 0;
			wid = 0;
			word <= w;
			hold_n <= h;
			go <= 1'b1;
			@(posedge clk_i);
			go <= 1'b0;
			while (ack !== 1'b1 && lat < 3000)
			begin
				@(negedge clk_i);
				lat++;
			end
			stored = mwr;
			while (ack === 1'b1 && wid < 3000)
			begin
				@(negedge clk_i);
				wid++;
				if (wid == 2)
					bn_at = bn_inh;
			end
			repeat (8) @(posedge clk_i);
		end
	endtask : send_word
	task automatic t_reset;
		begin
			chk({30'h0, ack, irq}, 32'h0);
			axi_rd(ack_seq_pkg::ADDR_STAT);
			chk(rd, 32'h0000_0020);
			axi_rd(ack_seq_pkg::ADDR_CTRL);
			chk(rd, 32'h0);
			axi_rd(8'h20);
			chk({rd[31:2], resp}, {30'h0, ack_seq_pkg::RESP_SLVERR});
			axi_wr(8'h22, 32'h1);
			chk({30'h0, resp}, {30'h0, ack_seq_pkg::RESP_SLVERR});
		end
	endtask : t_reset
	// Unpaired fast word, slow-dropping equipment.
	task automatic t_single;
		begin
			axi_wr(ack_seq_pkg::ADDR_CTRL, 32'h0000_0021);
			send_word(18'h2A5C3, 8'h64);
			chk({14'h0, stored}, 32'h0002_A5C3);
			chk({31'h0, lat < 16}, 32'h1);
			chk(wid, ack_seq_pkg::ACK_FAST_CYC);
			chk({29'h0, st_sel, wr_inh, cm_inh}, 32'h0);
			axi_wr(ack_seq_pkg::ADDR_RD_ADDR, 32'h0);
			axi_rd(ack_seq_pkg::ADDR_RD_DATA);
			chk(rd, 32'h0002_A5C3);
		end
	endtask : t_single
	// Paired word: acknowledge only in the second sequence.
	task automatic t_paired;
		begin
			axi_wr(ack_seq_pkg::ADDR_CTRL, 32'h0000_0023);
			send_word(18'h15A3C, 8'h0);
			chk({31'h0, lat >= 20}, 32'h1);
			chk({31'h0, bn_at}, 32'h0);
			chk(wid, ack_seq_pkg::ACK_FAST_CYC);
		end
	endtask : t_paired
	task automatic t_slow;
		begin
			axi_wr(ack_seq_pkg::ADDR_CTRL, 32'h0000_0025);
			send_word(18'h00FF0, 8'h0);
			chk(wid, ack_seq_pkg::ACK_SLOW_CYC);
			chk({14'h0, stored}, 32'h0000_0FF0);
		end
	endtask : t_slow
	// Channel set to indexed mode behaves as a paired channel.
	task automatic t_indexed;
		begin
			axi_wr(ack_seq_pkg::ADDR_CTRL, 32'h0000_0321);
			axi_wr(ack_seq_pkg::ADDR_FUNC, 32'h0000_0008);
			send_word(18'h3FFFF, 8'h0);
			chk({31'h0, lat >= 20}, 32'h1);
			axi_wr(ack_seq_pkg::ADDR_FUNC, 32'h0);
		end
	endtask : t_indexed
	// Monitor flag of channel 5, its interrupt masked and cleared.
	task automatic t_monitor;
		begin
			axi_wr(ack_seq_pkg::ADDR_INT_STAT, 32'hF);
			axi_wr(ack_seq_pkg::ADDR_INT_MASK, 32'h4);
			axi_wr(ack_seq_pkg::ADDR_CTRL, 32'h0000_0529);
			send_word(18'h00001, 8'h0);
			axi_rd(ack_seq_pkg::ADDR_MON);
			chk(rd, 32'h0000_0020);
			chk({31'h0, irq}, 32'h1);
			axi_wr(ack_seq_pkg::ADDR_INT_MASK, 32'h0);
			repeat (2) @(posedge clk_i);
			chk({31'h0, irq}, 32'h0);
			axi_wr(ack_seq_pkg::ADDR_INT_MASK, 32'h4);
			axi_wr(ack_seq_pkg::ADDR_INT_STAT, 32'h4);
			repeat (2) @(posedge clk_i);
			axi_rd(ack_seq_pkg::ADDR_INT_STAT);
			chk({29'h0, rd[2], irq}, 32'h0);
		end
	endtask : t_monitor
	// Clock enable low while the acknowledge stands stretches it by the frozen cycles.
	task automatic t_freeze;
		begin
			axi_wr(ack_seq_pkg::ADDR_CTRL, 32'h0000_0021);
			fork
				send_word(18'h2C0DE, 8'h0);
				begin
					wait (ack === 1'b1);
					@(posedge clk_i);
					ce <= 1'b0;
					repeat (10) @(posedge clk_i);
					ce <= 1'b1;
				end
			join
			chk(wid, ack_seq_pkg::ACK_FAST_CYC + 10);
		end
	endtask : t_freeze
	// Neither terminate nor continuous: the channel goes inactive after one word.
	task automatic t_deactivate;
		begin
			axi_wr(ack_seq_pkg::ADDR_CTRL, 32'h0000_0001);
			send_word(18'h12345, 8'h0);
			axi_rd(ack_seq_pkg::ADDR_STAT);
			chk({31'h0, rd[0]}, 32'h0);
			axi_rd(ack_seq_pkg::ADDR_INT_STAT);
			chk({31'h0, rd[3]}, 32'h1);
			send_word(18'h0ABCD, 8'h0);
			chk(lat, 3000);
		end
	endtask : t_deactivate
	// Main sequence.
	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_single();
		t_paired();
		t_slow();
		t_indexed();
		t_monitor();
		t_freeze();
		t_deactivate();
		final_report();
	end
endmodule : input_channel_ack_sequencer_test
`default_nettype wire
